/* sram_port_consts.svh */
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH
`define DATA_W 18
`define ADDR_W 21
`define CLK_PERIOD_NS 100
`define LINK_PERIOD_NS 800
`define LINK_HALF_CYCLES (`LINK_PERIOD_NS / `CLK_PERIOD_NS / 2)
`define LINK_DRIVE_POINT (`LINK_HALF_CYCLES / 2 - 1)
`define LAT_LONG_TICKS 5
`define LAT_SHORT_TICKS 2
`define RD_PIPE_DEPTH 5
`define FIFO_DEPTH 2
`endif

/* sram_port_pkg.sv */
`include "sram_port_consts.svh"
package sram_port_pkg;
	typedef logic [`DATA_W-1:0] word_t;
	typedef logic [`ADDR_W-1:0] addr_t;
endpackage : sram_port_pkg

/* sram_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sram_link_if;
	logic                 k;
	logic                 k_n;
	sram_port_pkg::addr_t addr;
	logic                 rd_sel_n;
	logic                 wr_sel_n;
	sram_port_pkg::word_t wr_data;
	logic                 pll_off_select;
	sram_port_pkg::word_t rd_data;
	logic                 read_data_valid;
	logic                 read_echo_clock;
	logic                 read_echo_clock_n;
	modport host_end (output k, k_n, addr, rd_sel_n, wr_sel_n, wr_data, pll_off_select,
		input rd_data, read_data_valid, read_echo_clock, read_echo_clock_n);
	modport device_end (input k, k_n, addr, rd_sel_n, wr_sel_n, wr_data, pll_off_select,
		output rd_data, read_data_valid, read_echo_clock, read_echo_clock_n);
endinterface : sram_link_if
`default_nettype wire

/* sram_device_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_consts.svh"
module sram_device_end (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	sram_link_if.device_end  link,
	output logic             o_wr_commit,
	output sram_port_pkg::addr_t o_wr_commit_addr
);
	localparam int MEM_WORDS = 1 << `ADDR_W;

	sram_port_pkg::word_t mem0 [0:MEM_WORDS-1];
	sram_port_pkg::word_t mem1 [0:MEM_WORDS-1];

	logic [1:0]           k_meta_reg;
	logic [1:0]           k_sync_reg;
	logic [1:0]           k_prev_reg;
	sram_port_pkg::addr_t addr_meta_reg;
	sram_port_pkg::addr_t addr_sync_reg;
	logic [1:0]           sel_meta_reg;
	logic [1:0]           sel_sync_reg;
	sram_port_pkg::word_t d_meta_reg;
	sram_port_pkg::word_t d_sync_reg;
	logic                 off_meta_reg;
	logic                 off_sync_reg;

	logic                 wr_pend_reg;
	sram_port_pkg::addr_t wr_addr_reg;
	sram_port_pkg::word_t wr_word0_reg;
	logic [`RD_PIPE_DEPTH-1:0]  rd_v_reg;
	sram_port_pkg::addr_t rd_a_reg [0:`RD_PIPE_DEPTH-1];
	sram_port_pkg::word_t q_reg;
	logic                 qv_reg;
	logic                 beat2_reg;
	sram_port_pkg::word_t word1_reg;
	logic                 echo_reg;
	logic                 commit_reg;
	sram_port_pkg::addr_t commit_addr_reg;

	// Input synchronisers; first stage is read only by the second.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			// Reset matches the idle link pins, k low and k_n high.
			k_meta_reg    <= 2'h2;
			k_sync_reg    <= 2'h2;
			k_prev_reg    <= 2'h2;
			addr_meta_reg <= '0;
			addr_sync_reg <= '0;
			sel_meta_reg  <= 2'h3;
			sel_sync_reg  <= 2'h3;
			d_meta_reg    <= '0;
			d_sync_reg    <= '0;
			off_meta_reg  <= 1'h0;
			off_sync_reg  <= 1'h0;
		end
		else
		begin
			k_meta_reg    <= {link.k_n, link.k};
			k_sync_reg    <= k_meta_reg;
			k_prev_reg    <= k_sync_reg;
			addr_meta_reg <= link.addr;
			addr_sync_reg <= addr_meta_reg;
			sel_meta_reg  <= {link.wr_sel_n, link.rd_sel_n};
			sel_sync_reg  <= sel_meta_reg;
			d_meta_reg    <= link.wr_data;
			d_sync_reg    <= d_meta_reg;
			off_meta_reg  <= link.pll_off_select;
			off_sync_reg  <= off_meta_reg;
		end
	end

	// Only rising edges of either link clock count; falling edges are ignored.
	wire k_rise  = k_sync_reg[0] & ~k_prev_reg[0];
	wire kn_rise = k_sync_reg[1] & ~k_prev_reg[1];
	wire tick    = k_rise | kn_rise;

	// Read address on the rise of k, write address on the rise of k_n.
	wire rd_capture = k_rise & ~sel_sync_reg[0];
	wire wr_capture = kn_rise & ~sel_sync_reg[1];
	wire wr_commit  = k_rise & wr_pend_reg;

	wire [2:0] lat_idx = off_sync_reg ? 3'(`LAT_LONG_TICKS - 1) : 3'(`LAT_SHORT_TICKS - 1);
	wire       launch  = tick & rd_v_reg[lat_idx];
	wire sram_port_pkg::addr_t launch_addr = rd_a_reg[lat_idx];

	// A write finishing in the launch tick is forwarded to the read.
	wire fwd = wr_commit & (wr_addr_reg == launch_addr);
	wire sram_port_pkg::word_t rd_w0 = fwd ? wr_word0_reg : mem0[launch_addr];
	wire sram_port_pkg::word_t rd_w1 = fwd ? d_sync_reg : mem1[launch_addr];

	// Input registers for the write burst.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_pend_reg  <= 1'h0;
			wr_addr_reg  <= '0;
			wr_word0_reg <= '0;
		end
		else if (wr_capture)
		begin
			wr_pend_reg  <= 1'h1;
			wr_addr_reg  <= addr_sync_reg;
			wr_word0_reg <= d_sync_reg;
		end
		else if (wr_commit)
		begin
			wr_pend_reg <= 1'h0;
		end
	end

	// Second write beat arrives on the following rise of k.
	always_ff @(posedge i_clk)
	begin
		if (wr_commit)
		begin
			mem0[wr_addr_reg] <= wr_word0_reg;
			mem1[wr_addr_reg] <= d_sync_reg;
		end
	end

	// Read requests age by one slot per link edge.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rd_v_reg[0] <= 1'h0;
			rd_a_reg[0] <= '0;
		end
		else if (tick)
		begin
			rd_v_reg[0] <= rd_capture;
			rd_a_reg[0] <= addr_sync_reg;
		end
	end

	genvar gi;
	generate
		for (gi = 1; gi < `RD_PIPE_DEPTH; gi = gi + 1)
		begin : g_rd_pipe
			always_ff @(posedge i_clk or negedge i_rstn)
			begin
				if (!i_rstn)
				begin
					rd_v_reg[gi] <= 1'h0;
					rd_a_reg[gi] <= '0;
				end
				else if (tick)
				begin
					rd_v_reg[gi] <= rd_v_reg[gi-1];
					rd_a_reg[gi] <= rd_a_reg[gi-1];
				end
			end
		end
	endgenerate

	// Output registers: two read beats, valid flag and echo clocks.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			q_reg     <= '0;
			qv_reg    <= 1'h0;
			beat2_reg <= 1'h0;
			word1_reg <= '0;
			echo_reg  <= 1'h0;
		end
		else if (tick)
		begin
			echo_reg <= ~echo_reg;
			if (launch)
			begin
				q_reg     <= rd_w0;
				word1_reg <= rd_w1;
				qv_reg    <= 1'h1;
				beat2_reg <= 1'h1;
			end
			else if (beat2_reg)
			begin
				q_reg     <= word1_reg;
				beat2_reg <= 1'h0;
			end
			else
			begin
				qv_reg <= 1'h0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			commit_reg      <= 1'h0;
			commit_addr_reg <= '0;
		end
		else
		begin
			commit_reg      <= wr_commit;
			commit_addr_reg <= wr_addr_reg;
		end
	end

	// Read and write paths share the array and the write-to-read forwarding path.
	assign link.rd_data           = q_reg;
	assign link.read_data_valid   = qv_reg;
	assign link.read_echo_clock   = echo_reg;
	assign link.read_echo_clock_n = ~echo_reg;
	assign o_wr_commit            = commit_reg;
	assign o_wr_commit_addr       = commit_addr_reg;
endmodule : sram_device_end
`default_nettype wire

/* sram_host_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_consts.svh"
module sram_host_end (
	input  wire logic                  i_clk,
	input  wire logic                  i_rstn,
	sram_link_if.host_end              link,
	input  wire logic                  i_pll_off_select,
	input  wire logic                  i_rd_valid,
	output logic                       o_rd_ready,
	input  wire sram_port_pkg::addr_t  i_rd_addr,
	input  wire logic                  i_wr_valid,
	output logic                       o_wr_ready,
	input  wire sram_port_pkg::addr_t  i_wr_addr,
	input  wire sram_port_pkg::word_t  i_wr_data0,
	input  wire sram_port_pkg::word_t  i_wr_data1,
	output logic                       o_q_valid,
	input  wire logic                  i_q_ready,
	output sram_port_pkg::word_t       o_q_data
);
	logic [1:0]           cnt_reg;
	logic                 k_reg;
	sram_port_pkg::addr_t addr_reg;
	logic                 rsel_n_reg;
	logic                 wsel_n_reg;
	sram_port_pkg::word_t d_reg;
	logic                 rd_pend_reg;
	logic                 rd_out_reg;
	sram_port_pkg::addr_t rd_addr_reg;
	logic                 wr_pend_reg;
	logic                 wr_second_reg;
	sram_port_pkg::addr_t wr_addr_reg;
	sram_port_pkg::word_t wr_d0_reg;
	sram_port_pkg::word_t wr_d1_reg;
	logic [2:0]           in_meta_reg;
	logic [2:0]           in_sync_reg;
	logic                 echo_prev_reg;
	sram_port_pkg::word_t q_meta_reg;
	sram_port_pkg::word_t q_sync_reg;
	logic                 beat_reg;
	sram_port_pkg::word_t fifo_reg [0:`FIFO_DEPTH-1];
	logic                 wptr_reg;
	logic                 rptr_reg;
	logic [1:0]           count_reg;

	wire half_end    = cnt_reg == 2'(`LINK_HALF_CYCLES - 1);
	wire drive_point = cnt_reg == 2'(`LINK_DRIVE_POINT);
	wire echo_edge   = (in_sync_reg[1] ^ echo_prev_reg) & in_sync_reg[0];
	wire push        = echo_edge;
	wire pop         = i_q_ready & (count_reg != 2'h0);

	assign o_rd_ready = ~rd_pend_reg & ~rd_out_reg & (count_reg == 2'h0);
	assign o_wr_ready = ~wr_pend_reg;
	assign o_q_valid  = count_reg != 2'h0;
	assign o_q_data   = fifo_reg[rptr_reg];

	// The link clock pair is divided from i_clk.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cnt_reg <= 2'h0;
			k_reg   <= 1'h0;
		end
		else
		begin
			cnt_reg <= half_end ? 2'h0 : 2'(cnt_reg + 2'h1);
			if (half_end)
			begin
				k_reg <= ~k_reg;
			end
		end
	end

	// Pins change mid half-period, so they are steady around each edge.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			addr_reg      <= '0;
			rsel_n_reg    <= 1'h1;
			wsel_n_reg    <= 1'h1;
			d_reg         <= '0;
			rd_pend_reg   <= 1'h0;
			rd_addr_reg   <= '0;
			wr_pend_reg   <= 1'h0;
			wr_second_reg <= 1'h0;
			wr_addr_reg   <= '0;
			wr_d0_reg     <= '0;
			wr_d1_reg     <= '0;
		end
		else
		begin
			if (i_rd_valid && o_rd_ready)
			begin
				rd_pend_reg <= 1'h1;
				rd_addr_reg <= i_rd_addr;
			end
			if (i_wr_valid && o_wr_ready)
			begin
				wr_pend_reg <= 1'h1;
				wr_addr_reg <= i_wr_addr;
				wr_d0_reg   <= i_wr_data0;
				wr_d1_reg   <= i_wr_data1;
			end
			if (drive_point && !k_reg)
			begin
				wsel_n_reg <= 1'h1;
				rsel_n_reg <= ~rd_pend_reg;
				if (rd_pend_reg)
				begin
					addr_reg    <= rd_addr_reg;
					rd_pend_reg <= 1'h0;
				end
				if (wr_second_reg)
				begin
					d_reg         <= wr_d1_reg;
					wr_second_reg <= 1'h0;
					wr_pend_reg   <= 1'h0;
				end
			end
			else if (drive_point && k_reg)
			begin
				rsel_n_reg <= 1'h1;
				wsel_n_reg <= ~(wr_pend_reg & ~wr_second_reg);
				if (wr_pend_reg && !wr_second_reg)
				begin
					addr_reg      <= wr_addr_reg;
					d_reg         <= wr_d0_reg;
					wr_second_reg <= 1'h1;
				end
			end
		end
	end

	// Read return pins pass two flip-flops before use.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			in_meta_reg   <= 3'h0;
			in_sync_reg   <= 3'h0;
			echo_prev_reg <= 1'h0;
			q_meta_reg    <= '0;
			q_sync_reg    <= '0;
		end
		else
		begin
			in_meta_reg   <= {link.read_echo_clock_n, link.read_echo_clock, link.read_data_valid};
			in_sync_reg   <= in_meta_reg;
			echo_prev_reg <= in_sync_reg[1];
			q_meta_reg    <= link.rd_data;
			q_sync_reg    <= q_meta_reg;
		end
	end

	// Two-entry return buffer; reads wait until it is empty.
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			fifo_reg[0] <= '0;
			fifo_reg[1] <= '0;
			wptr_reg    <= 1'h0;
			rptr_reg    <= 1'h0;
			count_reg   <= 2'h0;
			beat_reg    <= 1'h0;
			rd_out_reg  <= 1'h0;
		end
		else
		begin
			if (drive_point && !k_reg && rd_pend_reg)
			begin
				rd_out_reg <= 1'h1;
			end
			else if (push && beat_reg)
			begin
				rd_out_reg <= 1'h0;
			end
			if (push)
			begin
				fifo_reg[wptr_reg] <= q_sync_reg;
				wptr_reg           <= ~wptr_reg;
				beat_reg           <= ~beat_reg;
			end
			if (pop)
			begin
				rptr_reg <= ~rptr_reg;
			end
			count_reg <= 2'(count_reg + {1'h0, push} - {1'h0, pop});
		end
	end

	assign link.k              = k_reg;
	assign link.k_n            = ~k_reg;
	assign link.addr           = addr_reg;
	assign link.rd_sel_n       = rsel_n_reg;
	assign link.wr_sel_n       = wsel_n_reg;
	assign link.wr_data        = d_reg;
	assign link.pll_off_select = i_pll_off_select;
endmodule : sram_host_end
`default_nettype wire

/* sram_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_link_chk (
	input wire logic                 i_clk,
	input wire logic                 i_rstn,
	input wire logic                 k,
	input wire logic                 k_n,
	input wire logic                 rd_sel_n,
	input wire logic                 pll_off_select,
	input wire sram_port_pkg::word_t rd_data,
	input wire logic                 read_data_valid,
	input wire logic                 read_echo_clock,
	input wire logic                 read_echo_clock_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	k_pair_a: assert property (k_n == !k)
		else $error("link clocks not complementary");
	k_half_a: assert property ($rose(k) |-> k[*4] ##1 !k)
		else $error("link clock half period wrong");
	echo_pair_a: assert property (read_echo_clock_n == !read_echo_clock)
		else $error("echo clocks not complementary");
	echo_follow_a: assert property ($changed(k) |-> ##[2:4] $changed(read_echo_clock))
		else $error("echo clock missed a link edge");
	lat_long_a: assert property ($rose(k) && !rd_sel_n && pll_off_select
		|-> ##[22:24] $rose(read_data_valid))
		else $error("long read latency wrong");
	lat_short_a: assert property ($rose(k) && !rd_sel_n && !pll_off_select
		|-> ##[10:12] $rose(read_data_valid))
		else $error("short read latency wrong");
	desel_quiet_a: assert property ($rose(k) && rd_sel_n && pll_off_select
		|-> ##22 !$rose(read_data_valid) ##1 !$rose(read_data_valid)
		##1 !$rose(read_data_valid))
		else $error("valid without a selected read");
	valid_len_a: assert property ($rose(read_data_valid)
		|-> read_data_valid[*8] ##1 !read_data_valid)
		else $error("valid length wrong");
	beat_hold_a: assert property ($rose(read_data_valid) |=> $stable(rd_data)[*3])
		else $error("read beat not held");
	cover property ($rose(read_data_valid) && pll_off_select);
	cover property ($rose(read_data_valid) && !pll_off_select);
	cover property ($rose(k) && rd_sel_n);
endmodule : sram_link_chk
`default_nettype wire

/* separate_io_ddr_burst2_sram_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module separate_io_ddr_burst2_sram_port_tb;
	logic                 i_clk = 1'b0;
	logic                 i_rstn = 1'b0;
	logic                 pll = 1'b1;
	logic                 rd_valid = 1'b0;
	logic                 wr_valid = 1'b0;
	logic                 q_ready = 1'b1;
	sram_port_pkg::addr_t rd_addr = 21'h0;
	sram_port_pkg::addr_t wr_addr = 21'h0;
	sram_port_pkg::word_t wd0 = 18'h0;
	sram_port_pkg::word_t wd1 = 18'h0;
	wire logic            rd_ready;
	wire logic            wr_ready;
	wire logic            q_valid;
	wire logic            wr_commit;
	wire sram_port_pkg::word_t q_data;
	wire sram_port_pkg::addr_t commit_addr;
	int                   miscompares = 0;
	int                   checks_done = 0;
	int                   cycles = 0;
	sram_link_if link ();
	sram_host_end sram_host_end_inst (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
		.i_pll_off_select(pll), .i_rd_valid(rd_valid), .o_rd_ready(rd_ready),
		.i_rd_addr(rd_addr), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready),
		.i_wr_addr(wr_addr), .i_wr_data0(wd0), .i_wr_data1(wd1), .o_q_valid(q_valid),
		.i_q_ready(q_ready), .o_q_data(q_data));
	sram_device_end sram_device_end_inst (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
		.o_wr_commit(wr_commit), .o_wr_commit_addr(commit_addr));
	sram_link_chk sram_link_chk_inst (.i_clk(i_clk), .i_rstn(i_rstn), .k(link.k),
		.k_n(link.k_n), .rd_sel_n(link.rd_sel_n), .pll_off_select(link.pll_off_select),
		.rd_data(link.rd_data), .read_data_valid(link.read_data_valid),
		.read_echo_clock(link.read_echo_clock), .read_echo_clock_n(link.read_echo_clock_n));
	always #50 i_clk = ~i_clk;
	task results;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			results();
		end
	end
	// Writes one burst and waits for the device to commit it.
	task wr(input sram_port_pkg::addr_t a, input sram_port_pkg::word_t d0, d1);
		int n;
		@(negedge i_clk);
		wr_addr = a;
		wd0 = d0;
		wd1 = d1;
		wr_valid = 1'b1;
		n = 0;
		while (wr_ready !== 1'b1 && n < 200)
		begin
			@(negedge i_clk);
			n++;
		end
		@(negedge i_clk);
		wr_valid = 1'b0;
		n = 0;
		while (wr_commit !== 1'b1 && n < 200)
		begin
			@(negedge i_clk);
			n++;
		end
		`CHK(wr_commit, 1'b1)
		`CHK(commit_addr, a)
	endtask : wr
	// Reads one burst; a stall holds the return stream before draining it.
	task rd(input sram_port_pkg::addr_t a, input sram_port_pkg::word_t e0, e1, input int stall);
		int n;
		int m;
		sram_port_pkg::word_t g0;
		sram_port_pkg::word_t g1;
		@(negedge i_clk);
		rd_addr = a;
		rd_valid = 1'b1;
		q_ready = (stall == 0);
		n = 0;
		while (rd_ready !== 1'b1 && n < 200)
		begin
			@(negedge i_clk);
			n++;
		end
		@(negedge i_clk);
		rd_valid = 1'b0;
		if (stall > 0)
		begin
			repeat (stall) @(negedge i_clk);
			`CHK(q_valid, 1'b1)
			`CHK(rd_ready, 1'b0)
			q_ready = 1'b1;
		end
		n = 0;
		m = 0;
		g0 = 18'h0;
		g1 = 18'h0;
		while (m < 2 && n < 300)
		begin
			if (q_valid === 1'b1)
			begin
				if (m == 0)
					g0 = q_data;
				else
					g1 = q_data;
				m++;
			end
			@(negedge i_clk);
			n++;
		end
		`CHK(g0, e0)
		`CHK(g1, e1)
	endtask : rd
	initial
	begin
		repeat (3) @(negedge i_clk);
		i_rstn = 1'b1;
		wr(21'h00010, 18'h12345, 18'h2ABCD);
		rd(21'h00010, 18'h12345, 18'h2ABCD, 0);
		fork
			wr(21'h1FFFFF, 18'h3FFFF, 18'h00001);
			rd(21'h00010, 18'h12345, 18'h2ABCD, 0);
		join
		rd(21'h1FFFFF, 18'h3FFFF, 18'h00001, 60);
		wr(21'h00010, 18'h0F0F0, 18'h30303);
		wr(21'h00010, 18'h15555, 18'h2AAAA);
		rd(21'h00010, 18'h15555, 18'h2AAAA, 0);
		repeat (40) @(negedge i_clk);
		`CHK(q_valid, 1'b0)
		pll = 1'b0;
		repeat (20) @(negedge i_clk);
		rd(21'h1FFFFF, 18'h3FFFF, 18'h00001, 0);
		fork
			wr(21'h00000, 18'h00ABC, 18'h3F00F);
			rd(21'h00010, 18'h15555, 18'h2AAAA, 0);
		join
		rd(21'h00000, 18'h00ABC, 18'h3F00F, 0);
		fork
			wr(21'h00000, 18'h2D2D2, 18'h1E1E1);
			rd(21'h00000, 18'h2D2D2, 18'h1E1E1, 0);
		join
		results();
	end
endmodule : separate_io_ddr_burst2_sram_port_tb
`default_nettype wire
